//--- dls_core.sv
// Function
// - FD 2A nn loads the second index register from nn and nn+1.
// - A prefixed direct transfer takes 20 states as 4,4,3,3,3,3.
// - Opcode 22 nn stores the pointer pair low at nn, high at nn+1.
// - The unprefixed pointer pair store takes 16 states as 4,3,3,3,3.
// - ED 01dd0011 picks the source pair by its two-bit field.
// - The selectable pair store puts the low byte at nn, upper at nn+1.
// - The first operand byte is the address low byte, the second high.
// - DD 22 nn stores the first index register low at nn, high at nn+1.
// - FD 22 nn stores the second index register low at nn, high at nn+1.
// - F9 copies the pointer pair to the stack pointer in six states.
// - DD F9 moves the first index register to the stack pointer in 4+6.
module dls_core (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Memory bus.
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_rd,
    output logic mem_wr,
    input wire logic [7:0] mem_rdata,
    // Register file view.
    input wire logic [15:0] first_general_pair,
    input wire logic [15:0] second_general_pair,
    input wire logic [15:0] memory_pointer_pair,
    input wire logic [15:0] index_reg_x,
    output logic [15:0] index_reg_y,
    output logic [15:0] stack_pointer,
    // Status.
    output logic [15:0] pc,
    output logic instr_done,
    output logic flags_we
);
    dls_pkg::dls_state_e state_r;
    dls_pkg::dls_kind_e kind_r;
    logic [3:0] tcnt_r;
    logic [7:0] prefix_r;
    logic [15:0] addr_r;
    logic [15:0] src_r;
    logic [15:0] pc_r;
    logic [15:0] sp_src_r;
    logic last_t;
    logic [7:0] op;

    // Opcode and data bytes are taken on the last state of their cycle.
    assign last_t = (tcnt_r == 4'h1);
    assign op = mem_rdata;

    function automatic logic [15:0] pick_pair(input logic [1:0] sel,
            input logic [15:0] sp);
        unique case (sel)
            dls_pkg::SEL_FIRST: pick_pair = first_general_pair;
            dls_pkg::SEL_SECOND: pick_pair = second_general_pair;
            dls_pkg::SEL_PTR: pick_pair = memory_pointer_pair;
            dls_pkg::SEL_SP: pick_pair = sp;
        endcase
    endfunction : pick_pair

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= dls_pkg::DLS_FETCH;
            kind_r <= dls_pkg::DLS_K_NONE;
            tcnt_r <= dls_pkg::T_FETCH;
            prefix_r <= dls_pkg::DATA_RST;
            addr_r <= dls_pkg::REG_RST;
            src_r <= dls_pkg::REG_RST;
            sp_src_r <= dls_pkg::REG_RST;
            pc_r <= dls_pkg::REG_RST;
            instr_done <= 1'b0;
        end else begin
            instr_done <= 1'b0;
            if (!last_t) begin
                tcnt_r <= tcnt_r - 4'h1;
            end else begin
                unique case (state_r)
                    dls_pkg::DLS_FETCH: begin
                        pc_r <= pc_r + 16'h1;
                        prefix_r <= op;
                        if (op == dls_pkg::PFX_X || op == dls_pkg::PFX_Y ||
                                op == dls_pkg::PFX_ED) begin
                            state_r <= dls_pkg::DLS_FETCH2;
                            tcnt_r <= dls_pkg::T_FETCH;
                        end else if (op == dls_pkg::OP_ST_PTR) begin
                            kind_r <= dls_pkg::DLS_K_ST_PTR;
                            src_r <= memory_pointer_pair;
                            state_r <= dls_pkg::DLS_ADDR_LO;
                            tcnt_r <= dls_pkg::T_MEM;
                        end else if (op == dls_pkg::OP_SP_COPY) begin
                            sp_src_r <= memory_pointer_pair;
                            state_r <= dls_pkg::DLS_SP_WAIT;
                            tcnt_r <= dls_pkg::T_SP_COPY - dls_pkg::T_FETCH;
                        end else begin
                            instr_done <= 1'b1;
                            tcnt_r <= dls_pkg::T_FETCH;
                        end
                    end
                    dls_pkg::DLS_FETCH2: begin
                        pc_r <= pc_r + 16'h1;
                        tcnt_r <= dls_pkg::T_MEM;
                        state_r <= dls_pkg::DLS_ADDR_LO;
                        if (prefix_r == dls_pkg::PFX_Y &&
                                op == dls_pkg::OP_LD_IDX) begin
                            kind_r <= dls_pkg::DLS_K_LD_Y;
                        end else if (prefix_r == dls_pkg::PFX_X &&
                                op == dls_pkg::OP_ST_PTR) begin
                            kind_r <= dls_pkg::DLS_K_ST_X;
                            src_r <= index_reg_x;
                        end else if (prefix_r == dls_pkg::PFX_Y &&
                                op == dls_pkg::OP_ST_PTR) begin
                            kind_r <= dls_pkg::DLS_K_ST_Y;
                            src_r <= index_reg_y;
                        end else if (prefix_r == dls_pkg::PFX_ED &&
                                (op & dls_pkg::ED_ST_MASK) ==
                                dls_pkg::ED_ST_PAT) begin
                            kind_r <= dls_pkg::DLS_K_ST_PAIR;
                            src_r <= pick_pair(op[dls_pkg::SEL_LSB +: 2],
                                stack_pointer);
                        end else if (prefix_r == dls_pkg::PFX_X &&
                                op == dls_pkg::OP_SP_COPY) begin
                            sp_src_r <= index_reg_x;
                            state_r <= dls_pkg::DLS_SP_WAIT;
                            // The second fetch is part of the six states.
                            tcnt_r <= dls_pkg::T_SP_COPY - dls_pkg::T_FETCH;
                        end else begin
                            state_r <= dls_pkg::DLS_FETCH;
                            tcnt_r <= dls_pkg::T_FETCH;
                            instr_done <= 1'b1;
                        end
                    end
                    dls_pkg::DLS_ADDR_LO: begin
                        pc_r <= pc_r + 16'h1;
                        addr_r[7:0] <= op;
                        state_r <= dls_pkg::DLS_ADDR_HI;
                        tcnt_r <= dls_pkg::T_MEM;
                    end
                    dls_pkg::DLS_ADDR_HI: begin
                        pc_r <= pc_r + 16'h1;
                        addr_r[15:8] <= op;
                        state_r <= dls_pkg::DLS_MEM_LO;
                        tcnt_r <= dls_pkg::T_MEM;
                    end
                    dls_pkg::DLS_MEM_LO: begin
                        state_r <= dls_pkg::DLS_MEM_HI;
                        tcnt_r <= dls_pkg::T_MEM;
                    end
                    dls_pkg::DLS_MEM_HI: begin
                        state_r <= dls_pkg::DLS_FETCH;
                        tcnt_r <= dls_pkg::T_FETCH;
                        instr_done <= 1'b1;
                    end
                    dls_pkg::DLS_SP_WAIT: begin
                        state_r <= dls_pkg::DLS_FETCH;
                        tcnt_r <= dls_pkg::T_FETCH;
                        instr_done <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Second index register and stack pointer updates.
    always_ff @(posedge clock) begin
        if (rst) begin
            index_reg_y <= dls_pkg::REG_RST;
            stack_pointer <= dls_pkg::REG_RST;
        end else if (last_t) begin
            if (kind_r == dls_pkg::DLS_K_LD_Y &&
                    state_r == dls_pkg::DLS_MEM_LO) begin
                index_reg_y[7:0] <= mem_rdata;
            end
            if (kind_r == dls_pkg::DLS_K_LD_Y &&
                    state_r == dls_pkg::DLS_MEM_HI) begin
                index_reg_y[15:8] <= mem_rdata;
            end
            if (state_r == dls_pkg::DLS_SP_WAIT) begin
                stack_pointer <= sp_src_r;
            end
        end
    end

    // Bus outputs are registered one state ahead of the cycle they serve.
    logic [15:0] addr_nxt;
    dls_pkg::dls_state_e st_nxt;
    always_comb begin
        st_nxt = state_r;
        if (last_t) begin
            unique case (state_r)
                dls_pkg::DLS_ADDR_HI: st_nxt = dls_pkg::DLS_MEM_LO;
                dls_pkg::DLS_MEM_LO: st_nxt = dls_pkg::DLS_MEM_HI;
                default: st_nxt = dls_pkg::DLS_FETCH;
            endcase
        end
        addr_nxt = {op, addr_r[7:0]};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mem_addr <= dls_pkg::REG_RST;
            mem_wdata <= dls_pkg::DATA_RST;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            pc <= dls_pkg::REG_RST;
            flags_we <= 1'b0;
        end else begin
            pc <= pc_r;
            flags_we <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            if (state_r == dls_pkg::DLS_ADDR_HI && last_t) begin
                mem_addr <= addr_nxt;
                mem_wdata <= src_r[7:0];
                mem_rd <= (kind_r == dls_pkg::DLS_K_LD_Y);
                mem_wr <= (kind_r != dls_pkg::DLS_K_LD_Y);
            end else if (state_r == dls_pkg::DLS_MEM_LO) begin
                mem_rd <= (kind_r == dls_pkg::DLS_K_LD_Y) && !last_t;
                mem_wr <= (kind_r != dls_pkg::DLS_K_LD_Y) && !last_t;
                if (last_t) begin
                    mem_addr <= addr_r + 16'h1;
                    mem_wdata <= src_r[15:8];
                    mem_rd <= (kind_r == dls_pkg::DLS_K_LD_Y);
                    mem_wr <= (kind_r != dls_pkg::DLS_K_LD_Y);
                end
            end else if (state_r == dls_pkg::DLS_MEM_HI && !last_t) begin
                mem_rd <= (kind_r == dls_pkg::DLS_K_LD_Y);
                mem_wr <= (kind_r != dls_pkg::DLS_K_LD_Y);
            end else if (st_nxt != dls_pkg::DLS_MEM_LO) begin
                // Only the byte-taking states bump pc_r on their last edge.
                mem_addr <= (last_t && state_r != dls_pkg::DLS_MEM_HI &&
                    state_r != dls_pkg::DLS_SP_WAIT) ? pc_r + 16'h1 : pc_r;
                mem_rd <= (st_nxt == dls_pkg::DLS_FETCH ||
                    state_r != dls_pkg::DLS_SP_WAIT) &&
                    st_nxt != dls_pkg::DLS_SP_WAIT;
            end
        end
    end

    no_flag_write_a: assert property (
        @(posedge clock) disable iff (rst)
        !flags_we) else $error("flag write seen");
    sp_copy_a: assert property (
        @(posedge clock) disable iff (rst)
        (state_r == dls_pkg::DLS_SP_WAIT && last_t) |=>
        stack_pointer == $past(sp_src_r)) else $error("sp copy");
    idx_copy_a: assert property (
        @(posedge clock) disable iff (rst)
        (state_r == dls_pkg::DLS_FETCH2 && last_t &&
        prefix_r == dls_pkg::PFX_X && op == dls_pkg::OP_SP_COPY) |->
        ##3 stack_pointer == $past(index_reg_x, 3)) else $error("sp ix");
    mem_phase_a: assert property (
        @(posedge clock) disable iff (rst)
        $rose(state_r == dls_pkg::DLS_MEM_LO) |->
        (state_r == dls_pkg::DLS_MEM_LO) [*3] ##1
        state_r == dls_pkg::DLS_MEM_HI) else $error("mem len");
    addr_phase_a: assert property (
        @(posedge clock) disable iff (rst)
        $rose(state_r == dls_pkg::DLS_ADDR_LO) |-> ##3
        state_r == dls_pkg::DLS_ADDR_HI) else $error("addr len");
    hi_addr_a: assert property (
        @(posedge clock) disable iff (rst)
        (state_r == dls_pkg::DLS_MEM_LO && last_t) |=>
        mem_addr == addr_r + 16'h1) else $error("hi addr");
    lo_addr_a: assert property (
        @(posedge clock) disable iff (rst)
        (state_r == dls_pkg::DLS_ADDR_HI && last_t) |=>
        mem_addr == addr_r) else $error("lo addr");
    y_low_a: assert property (
        @(posedge clock) disable iff (rst)
        (kind_r == dls_pkg::DLS_K_LD_Y && state_r == dls_pkg::DLS_MEM_LO
        && last_t) |=> index_reg_y[7:0] == $past(mem_rdata))
        else $error("iy low");
    store_c: cover property (@(posedge clock)
        kind_r == dls_pkg::DLS_K_ST_PAIR && instr_done);
    load_c: cover property (@(posedge clock)
        kind_r == dls_pkg::DLS_K_LD_Y && instr_done);
    spc_c: cover property (@(posedge clock)
        state_r == dls_pkg::DLS_SP_WAIT && last_t);
endmodule : dls_core

//--- dls_pkg.sv
package dls_pkg;
    localparam logic [7:0] PFX_X = 8'hdd;
    localparam logic [7:0] PFX_Y = 8'hfd;
    localparam logic [7:0] PFX_ED = 8'hed;
    localparam logic [7:0] OP_LD_IDX = 8'h2a;
    localparam logic [7:0] OP_ST_PTR = 8'h22;
    localparam logic [7:0] OP_SP_COPY = 8'hf9;
    localparam logic [7:0] ED_ST_MASK = 8'hcf;
    localparam logic [7:0] ED_ST_PAT = 8'h43;
    localparam int SEL_LSB = 4;
    localparam logic [1:0] SEL_FIRST = 2'h0;
    localparam logic [1:0] SEL_SECOND = 2'h1;
    localparam logic [1:0] SEL_PTR = 2'h2;
    localparam logic [1:0] SEL_SP = 2'h3;
    localparam logic [3:0] T_FETCH = 4'h4;
    localparam logic [3:0] T_MEM = 4'h3;
    localparam logic [3:0] T_SP_COPY = 4'h6;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef enum logic [6:0] {
        DLS_FETCH = 7'b0000001,
        DLS_FETCH2 = 7'b0000010,
        DLS_ADDR_LO = 7'b0000100,
        DLS_ADDR_HI = 7'b0001000,
        DLS_MEM_LO = 7'b0010000,
        DLS_MEM_HI = 7'b0100000,
        DLS_SP_WAIT = 7'b1000000
    } dls_state_e;

    typedef enum logic [2:0] {
        DLS_K_LD_Y = 3'h0,
        DLS_K_ST_PTR = 3'h1,
        DLS_K_ST_PAIR = 3'h2,
        DLS_K_ST_X = 3'h3,
        DLS_K_ST_Y = 3'h4,
        DLS_K_NONE = 3'h5
    } dls_kind_e;
endpackage : dls_pkg

//--- dls_mem_model.sv
module dls_mem_model (
    // Clock.
    input wire logic clock,
    // Bus from the core.
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_rd,
    input wire logic mem_wr,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h5a;
    // The bench preloads the array, so this process is not always_ff.
    always @(posedge clock) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
    always @(posedge clock) begin
        if (mem_rd) begin
            last_r <= mem[mem_addr];
        end
    end
    // An unselected bus shows the inverse of the last byte, not a stale copy.
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_r;
endmodule : dls_mem_model

//--- sixteen_bit_direct_load_store_test.sv
module sixteen_bit_direct_load_store_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int K_LDY = 0, K_PTR = 1, K_PAIR = 2, K_X = 3, K_Y = 4;
    localparam int K_SPP = 5, K_SPX = 6, K_NOP = 7;
    logic clock, rst, mem_rd, mem_wr, instr_done, flags_we;
    logic [15:0] mem_addr, index_reg_y, stack_pointer, pc;
    logic [7:0] mem_wdata, mem_rdata;
    logic [15:0] first_general_pair, second_general_pair;
    logic [15:0] memory_pointer_pair, index_reg_x, exp_y, exp_sp, v, got;
    logic [31:0] seed = 32'h0000004e;
    int mismatches = 0, compares = 0, wr = 0, cnt;
    int kind[$], sel[$], tlen[$];
    logic [15:0] nn[$];

    dls_core dut_u (.clock(clock), .rst(rst), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_rdata(mem_rdata), .first_general_pair(first_general_pair),
        .second_general_pair(second_general_pair),
        .memory_pointer_pair(memory_pointer_pair),
        .index_reg_x(index_reg_x), .index_reg_y(index_reg_y),
        .stack_pointer(stack_pointer), .pc(pc), .instr_done(instr_done),
        .flags_we(flags_we));
    dls_mem_model mem_u (.clock(clock), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_rdata(mem_rdata));

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand

    task automatic put(input logic [7:0] b);
        mem_u.mem[wr] = b;
        wr++;
    endtask : put

    // Appends one instruction to the program and records what it should do.
    task automatic add(input int k, input int s, input logic [7:0] pf,
                       input logic [7:0] op, input int t);
        logic [31:0] r;
        logic [15:0] a;
        r = next_rand();
        a = 16'h4000 + 16'(kind.size() * 64) + 16'(r[4:0]);
        if (pf != 8'h00) put(pf);
        put(op);
        if (k < K_SPP) begin
            put(a[7:0]);
            put(a[15:8]);
        end
        if (k == K_LDY) begin
            mem_u.mem[a] = r[15:8];
            mem_u.mem[a + 16'h1] = r[23:16];
            exp_y = r[23:8];
        end
        kind.push_back(k);
        sel.push_back(s);
        nn.push_back(a);
        tlen.push_back(t);
    endtask : add

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        rst = 1'b1;
        for (int i = 0; i < 65536; i++) mem_u.mem[i] = 8'h00;
        first_general_pair = 16'(next_rand());
        second_general_pair = 16'(next_rand());
        memory_pointer_pair = 16'(next_rand());
        index_reg_x = 16'(next_rand());
        add(K_SPP, 0, 8'h00, 8'hf9, 6);
        add(K_LDY, 0, 8'hfd, 8'h2a, 20);
        add(K_PTR, 0, 8'h00, 8'h22, 16);
        for (int s = 0; s < 4; s++) begin
            add(K_PAIR, s, 8'hed, 8'(8'h43 | (s << 4)), 20);
        end
        add(K_X, 0, 8'hdd, 8'h22, 20);
        add(K_Y, 0, 8'hfd, 8'h22, 20);
        add(K_SPX, 0, 8'hdd, 8'hf9, 10);
        add(K_PAIR, 3, 8'hed, 8'h73, 20);
        // Undecoded bytes finish as one or two fetches with no effect.
        add(K_NOP, 0, 8'h00, 8'h00, 4);
        add(K_NOP, 0, 8'hed, 8'h47, 8);
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < kind.size(); i++) begin
            cnt = 0;
            do begin
                @(negedge clock);
                cnt++;
            end while (instr_done !== 1'b1 && cnt < 100);
            chk(16'(cnt), 16'(tlen[i]), "states");
            chk(16'(flags_we), 16'h0, "flags write");
            got = {mem_u.mem[nn[i] + 16'h1], mem_u.mem[nn[i]]};
            v = (sel[i] == 0) ? first_general_pair :
                (sel[i] == 1) ? second_general_pair :
                (sel[i] == 2) ? memory_pointer_pair : exp_sp;
            case (kind[i])
                K_LDY: chk(index_reg_y, exp_y, "index y");
                K_PTR: chk(got, memory_pointer_pair, "store");
                K_X: chk(got, index_reg_x, "store x");
                K_Y: chk(got, exp_y, "store y");
                K_PAIR: chk(got, v, "store pair");
                K_SPP: exp_sp = memory_pointer_pair;
                K_SPX: exp_sp = index_reg_x;
                default: ;
            endcase
            if (kind[i] >= K_SPP) begin
                chk(stack_pointer, exp_sp, "stack");
            end
            $display("test %0d kind %0d done", i, kind[i]);
        end
        // The program counter view trails the internal count by one edge.
        @(negedge clock);
        chk(pc, 16'(wr), "program counter");
        end_sim();
    end
endmodule : sixteen_bit_direct_load_store_test
